//--- rtl/frp_consts.svh
// Constants for the motor driver fault protection block
`ifndef FRP_CONSTS_SVH
`define FRP_CONSTS_SVH

`define FRP_CLK_NS      10
`define FRP_MS_CYC(ms)  ((ms) * 1000000 / `FRP_CLK_NS)
`define FRP_NS_CYC(ns)  (((ns) + `FRP_CLK_NS - 1) / `FRP_CLK_NS)

// Overcurrent deglitch settings, ns
`define FRP_OCD_T0_NS   250
`define FRP_OCD_T1_NS   500
`define FRP_OCD_T2_NS   1000
`define FRP_OCD_T3_NS   2000
// Current limit deglitch settings, ns
`define FRP_ILD_T0_NS   1000
`define FRP_ILD_T1_NS   2000
`define FRP_ILD_T2_NS   5000
`define FRP_ILD_T3_NS   10000
// Retry times, ms
`define FRP_OCR_A_MS    5
`define FRP_OCR_B_MS    50
`define FRP_STR_A_MS    500
`define FRP_STR_B_MS    1000

`define FRP_DG_W        10
`define FRP_RT_W        27

// Synchronised input vector layout
`define FRP_SY_W        14
`define FRP_SY_OV       0
`define FRP_SY_OCP_LO   1
`define FRP_SY_BUCK     7
`define FRP_SY_ILIM     8
`define FRP_SY_OTW      9
`define FRP_SY_TSD      10
`define FRP_SY_STL_LO   11

`endif

//--- rtl/frp_pkg.sv
// Types for the motor driver fault protection block
package frp_pkg;

  typedef enum logic [1:0] {
    FRP_CL_LATCH  = 2'h0,
    FRP_CL_RETRY  = 2'h1,
    FRP_CL_REPORT = 2'h2,
    FRP_CL_IGNORE = 2'h3
  } frp_class_t;

  typedef enum logic [2:0] {
    FRP_BR_DRIVE  = 3'h0,
    FRP_BR_OFF    = 3'h1,
    FRP_BR_RECIRC = 3'h2,
    FRP_BR_HS_ON  = 3'h3,
    FRP_BR_LS_ON  = 3'h4
  } frp_bridge_t;

endpackage

//--- rtl/frp_resp.sv
// Per-fault response engine: latch, timed retry, report or ignore
`timescale 1ns/100ps
`include "frp_consts.svh"

module frp_resp
  import frp_pkg::*;
(
  input  wire logic               i_mclk,      // System clock
  input  wire logic               i_rst_n,     // Async reset, active low
  input  wire logic               i_event,     // Event level, deglitched for overcurrent and limit, synchronised only for stall
  input  wire frp_class_t         i_class,     // Response class
  input  wire logic               i_cond,      // Raw condition still present
  input  wire logic               i_clear,     // Clear-fault pulse
  input  wire logic [`FRP_RT_W-1:0] i_retry_cyc, // Retry length in cycles
  output logic                    o_active,    // Protective action in force
  output logic                    o_report     // Fault being reported
);

  logic                 hold_r;
  logic                 hold_nxt;
  logic [`FRP_RT_W-1:0] cnt_r;
  logic [`FRP_RT_W-1:0] cnt_nxt;

  always_comb
  begin
    hold_nxt = hold_r;
    cnt_nxt  = cnt_r;
    unique case (i_class)
      FRP_CL_LATCH, FRP_CL_REPORT:
      begin
        cnt_nxt = '0;
        // Event wins over a clear in the same cycle
        if (i_event)
          hold_nxt = 1'b1;
        else if (i_clear && !i_cond)
          hold_nxt = 1'b0;
      end
      FRP_CL_RETRY:
      begin
        hold_nxt = 1'b0;
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else if (i_event)
          cnt_nxt = i_retry_cyc;
      end
      FRP_CL_IGNORE:
      begin
        hold_nxt = 1'b0;
        cnt_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_r <= 1'b0;
      cnt_r  <= '0;
    end
    else
    begin
      hold_r <= hold_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign o_active = (hold_r && i_class == FRP_CL_LATCH) || (cnt_r != '0);
  assign o_report = hold_r || (cnt_r != '0);

endmodule // frp_resp

//--- rtl/frp_top.sv
// Fault-response logic of the three-phase motor driver
`timescale 1ns/100ps
`include "frp_consts.svh"

module frp_top
  import frp_pkg::*;
#(
  parameter int unsigned OC_RETRY_A_CYC    = `FRP_MS_CYC(`FRP_OCR_A_MS),
  parameter int unsigned OC_RETRY_B_CYC    = `FRP_MS_CYC(`FRP_OCR_B_MS),
  parameter int unsigned STALL_RETRY_A_CYC = `FRP_MS_CYC(`FRP_STR_A_MS),
  parameter int unsigned STALL_RETRY_B_CYC = `FRP_MS_CYC(`FRP_STR_B_MS)
)
(
  input  wire logic       i_mclk,                      // 100 MHz clock
  input  wire logic       i_rst_n,                     // Async reset, active low
  // Analog detector flags, asynchronous
  input  wire logic       i_motor_supply_ov,           // Supply above trip level
  input  wire logic [5:0] i_fet_oc,                    // Per-FET current above level
  input  wire logic       i_buck_oc,                   // Buck high-side over limit
  input  wire logic       i_current_sense_amp_over,    // Sense amp above limit
  input  wire logic       i_thermal_warning,           // Die above warning limit
  input  wire logic       i_thermal_shutdown,          // Die above shutdown limit
  input  wire logic [2:0] i_stall_cond,                // Stall detector conditions
  // Configuration, same clock domain
  input  wire logic       i_overvoltage_enable,        // Enable supply protection
  input  wire logic       i_overvoltage_level_select,  // 0: 20 V, 1: 32 V
  input  wire logic [1:0] i_overcurrent_response_mode, // Overcurrent mode
  input  wire logic [1:0] i_overcurrent_level,         // Overcurrent threshold code
  input  wire logic [1:0] i_overcurrent_deglitch,      // Overcurrent deglitch code
  input  wire logic       i_overcurrent_retry_time,    // Overcurrent retry select
  input  wire logic       i_alarm_pin_disable,         // Report-only off the pin
  input  wire logic [3:0] i_hw_current_limit,          // Current limit threshold code
  input  wire logic [3:0] i_hw_current_limit_mode,     // Current limit mode
  input  wire logic [1:0] i_hw_current_limit_deglitch, // Current limit deglitch code
  input  wire logic       i_stall_retry_time,          // Stall and limit retry select
  input  wire logic [2:0] i_stall_enable,              // Per-condition stall enable
  input  wire logic [3:0] i_motor_stall_mode,          // Stall mode
  input  wire logic       i_thermal_warning_report,    // Warning drives the pin
  input  wire logic       i_clear_fault_cmd,           // Clear-fault pulse
  // Power stage
  output logic            o_fault_out_n,               // Fault pin, active low
  output frp_bridge_t     o_bridge_state,              // Bridge output state
  output logic            o_charge_pump_en,            // Charge pump enable
  output logic            o_device_reset,              // Buck overcurrent reset
  output logic            o_overvoltage_level_select,  // Comparator trip select
  output logic [1:0]      o_overcurrent_level,         // Comparator threshold
  output logic [3:0]      o_hw_current_limit,          // Comparator threshold
  // Status
  output logic            o_driver_fault,              // Driver fault summary
  output logic            o_controller_fault,          // Controller fault summary
  output logic            o_overvoltage_flag,          // Sticky overvoltage
  output logic            o_overcurrent_flag,          // Sticky overcurrent
  output logic [5:0]      o_fet_oc_flag,               // Sticky per-FET overcurrent
  output logic            o_hw_current_limit_flag,     // Current limit reported
  output logic            o_over_temp_flag,            // Sticky over-temperature
  output logic            o_thermal_warning_flag,      // Sticky thermal warning
  output logic            o_thermal_shutdown_flag,     // Sticky thermal shutdown
  output logic            o_motor_stall_event,         // Stall reported
  output logic [2:0]      o_stall_cond_flag            // Stall condition bits
);

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [`FRP_SY_W-1:0] meta_r;
  logic [`FRP_SY_W-1:0] sy_r;
  logic [`FRP_SY_W-1:0] raw;

  assign raw = {i_stall_cond, i_thermal_shutdown, i_thermal_warning, i_current_sense_amp_over,
                i_buck_oc, i_fet_oc, i_motor_supply_ov};

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '0;
      sy_r   <= '0;
    end
    else
    begin
      meta_r <= raw;
      sy_r   <= meta_r;
    end
  end

  logic       ov_act;
  logic [5:0] fet_s;
  logic       oc_cond;
  logic       otw_s;
  logic       tsd_s;
  logic [2:0] stl_s;

  assign ov_act  = sy_r[`FRP_SY_OV] & i_overvoltage_enable;
  assign fet_s   = sy_r[`FRP_SY_OCP_LO +: 6];
  assign oc_cond = |fet_s;
  assign otw_s   = sy_r[`FRP_SY_OTW];
  assign tsd_s   = sy_r[`FRP_SY_TSD];
  assign stl_s   = sy_r[`FRP_SY_STL_LO +: 3] & i_stall_enable;

  // --------------------------------------------------------------
  // Deglitch: 0 overcurrent, 1 buck, 2 current limit
  // --------------------------------------------------------------
  logic [`FRP_DG_W-1:0] dg_cnt_r [3];
  logic [`FRP_DG_W-1:0] dg_cnt_nxt [3];
  logic [`FRP_DG_W-1:0] dg_lim [3];
  logic [2:0]           dg_in;
  logic [2:0]           dg_det;

  assign dg_in = {sy_r[`FRP_SY_ILIM], sy_r[`FRP_SY_BUCK], oc_cond};

  always_comb
  begin
    unique case (i_overcurrent_deglitch)
      2'h0: dg_lim[0] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_OCD_T0_NS));
      2'h1: dg_lim[0] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_OCD_T1_NS));
      2'h2: dg_lim[0] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_OCD_T2_NS));
      2'h3: dg_lim[0] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_OCD_T3_NS));
    endcase
    dg_lim[1] = dg_lim[0];
    unique case (i_hw_current_limit_deglitch)
      2'h0: dg_lim[2] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_ILD_T0_NS));
      2'h1: dg_lim[2] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_ILD_T1_NS));
      2'h2: dg_lim[2] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_ILD_T2_NS));
      2'h3: dg_lim[2] = `FRP_DG_W'(`FRP_NS_CYC(`FRP_ILD_T3_NS));
    endcase
    for (int i = 0; i < 3; i++)
    begin
      // Any dropout restarts the qualification window
      if (!dg_in[i])
        dg_cnt_nxt[i] = '0;
      else if (dg_cnt_r[i] < dg_lim[i])
        dg_cnt_nxt[i] = dg_cnt_r[i] + 1'b1;
      else
        dg_cnt_nxt[i] = dg_cnt_r[i];
      dg_det[i] = dg_in[i] && (dg_cnt_r[i] >= dg_lim[i]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      for (int i = 0; i < 3; i++)
        dg_cnt_r[i] <= '0;
    else
      for (int i = 0; i < 3; i++)
        dg_cnt_r[i] <= dg_cnt_nxt[i];
  end

  // --------------------------------------------------------------
  // Mode decode and response engines
  // --------------------------------------------------------------
  frp_class_t           oc_cls;
  frp_class_t           il_cls;
  frp_class_t           st_cls;
  logic [`FRP_RT_W-1:0] oc_retry;
  logic [`FRP_RT_W-1:0] st_retry;
  logic                 oc_act;
  logic                 oc_rep;
  logic                 il_act;
  logic                 il_rep;
  logic                 st_act;
  logic                 st_rep;

  function automatic frp_class_t cls4(input logic [3:0] m);
    // 1x10 and 1100 codes fall back to report only
    if (m[3])
      cls4 = m[0] ? FRP_CL_IGNORE : FRP_CL_REPORT;
    else
      cls4 = m[2] ? FRP_CL_RETRY : FRP_CL_LATCH;
  endfunction

  function automatic frp_bridge_t br_of(input logic [1:0] low);
    unique case (low)
      2'h0: br_of = FRP_BR_OFF;
      2'h1: br_of = FRP_BR_RECIRC;
      2'h2: br_of = FRP_BR_HS_ON;
      2'h3: br_of = FRP_BR_LS_ON;
    endcase
  endfunction

  assign oc_cls   = frp_class_t'(i_overcurrent_response_mode);
  assign il_cls   = cls4(i_hw_current_limit_mode);
  assign st_cls   = cls4(i_motor_stall_mode);
  assign oc_retry = i_overcurrent_retry_time ? `FRP_RT_W'(OC_RETRY_B_CYC) : `FRP_RT_W'(OC_RETRY_A_CYC);
  assign st_retry = i_stall_retry_time ? `FRP_RT_W'(STALL_RETRY_B_CYC) : `FRP_RT_W'(STALL_RETRY_A_CYC);

  frp_resp u_oc (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_event     (dg_det[0]),
    .i_class     (oc_cls),
    .i_cond      (oc_cond),
    .i_clear     (i_clear_fault_cmd),
    .i_retry_cyc (oc_retry),
    .o_active    (oc_act),
    .o_report    (oc_rep)
  );

  frp_resp u_ilim (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_event     (dg_det[2]),
    .i_class     (il_cls),
    .i_cond      (sy_r[`FRP_SY_ILIM]),
    .i_clear     (i_clear_fault_cmd),
    .i_retry_cyc (st_retry),
    .o_active    (il_act),
    .o_report    (il_rep)
  );

  frp_resp u_stall (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_event     (|stl_s),
    .i_class     (st_cls),
    .i_cond      (|stl_s),
    .i_clear     (i_clear_fault_cmd),
    .i_retry_cyc (st_retry),
    .o_active    (st_act),
    .o_report    (st_rep)
  );

  // --------------------------------------------------------------
  // Status, bridge and pin
  // --------------------------------------------------------------
  logic        clr;
  logic        oc_ev;
  logic [2:0]  st_ev;
  logic        fault_n_nxt;
  frp_bridge_t bridge_nxt;
  logic        ovf_nxt;
  logic        ocf_nxt;
  logic [5:0]  fet_nxt;
  logic        ot_nxt;
  logic        otw_nxt;
  logic        tsd_nxt;
  logic [2:0]  stc_nxt;
  logic        drvf_nxt;
  logic        ctlf_nxt;

  assign clr = i_clear_fault_cmd;

  always_comb
  begin
    oc_ev = dg_det[0] && oc_cls != FRP_CL_IGNORE;
    st_ev = stl_s & {3{st_cls != FRP_CL_IGNORE}};
    // Sticky bits: a new event always beats the clear
    ovf_nxt = ov_act | (o_overvoltage_flag & ~(clr & ~ov_act));
    ocf_nxt = oc_ev | (o_overcurrent_flag & ~(clr & ~oc_cond));
    fet_nxt = (fet_s & {6{oc_ev}}) | (o_fet_oc_flag & ~{6{clr & ~oc_cond}});
    otw_nxt = otw_s | (o_thermal_warning_flag & ~(clr & ~otw_s));
    ot_nxt  = otw_s | tsd_s | (o_over_temp_flag & ~(clr & ~otw_s & ~tsd_s));
    tsd_nxt = tsd_s | (o_thermal_shutdown_flag & ~(clr & ~tsd_s));
    // Condition bits follow the stall report and clear in the same cycle as o_motor_stall_event
    stc_nxt = st_ev | (o_stall_cond_flag & {3{st_rep}});
    drvf_nxt = ov_act | tsd_s | oc_rep;
    ctlf_nxt = il_rep | st_rep;
    // Supply, thermal and FET faults outrank the limit and stall states
    if (ov_act || tsd_s || oc_act)
      bridge_nxt = FRP_BR_OFF;
    else if (il_act)
      bridge_nxt = br_of(i_hw_current_limit_mode[1:0]);
    else if (st_act)
      bridge_nxt = br_of(i_motor_stall_mode[1:0]);
    else
      bridge_nxt = FRP_BR_DRIVE;
    fault_n_nxt = ~(ov_act | tsd_s | oc_act | il_act | st_act
                  | ((oc_rep | il_rep | st_rep) & ~i_alarm_pin_disable)
                  | (otw_s & i_thermal_warning_report));
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fault_out_n              <= 1'b1;
      o_bridge_state             <= FRP_BR_DRIVE;
      o_charge_pump_en           <= 1'b1;
      o_device_reset             <= 1'b0;
      o_overvoltage_level_select <= 1'b0;
      o_overcurrent_level        <= 2'h0;
      o_hw_current_limit         <= 4'h0;
      o_driver_fault             <= 1'b0;
      o_controller_fault         <= 1'b0;
      o_overvoltage_flag         <= 1'b0;
      o_overcurrent_flag         <= 1'b0;
      o_fet_oc_flag              <= 6'h00;
      o_hw_current_limit_flag    <= 1'b0;
      o_over_temp_flag           <= 1'b0;
      o_thermal_warning_flag     <= 1'b0;
      o_thermal_shutdown_flag    <= 1'b0;
      o_motor_stall_event        <= 1'b0;
      o_stall_cond_flag          <= 3'h0;
    end
    else
    begin
      o_fault_out_n              <= fault_n_nxt;
      o_bridge_state             <= bridge_nxt;
      o_charge_pump_en           <= ~tsd_s;
      o_device_reset             <= dg_det[1];
      o_overvoltage_level_select <= i_overvoltage_level_select;
      o_overcurrent_level        <= i_overcurrent_level;
      o_hw_current_limit         <= i_hw_current_limit;
      o_driver_fault             <= drvf_nxt;
      o_controller_fault         <= ctlf_nxt;
      o_overvoltage_flag         <= ovf_nxt;
      o_overcurrent_flag         <= ocf_nxt;
      o_fet_oc_flag              <= fet_nxt;
      o_hw_current_limit_flag    <= il_rep;
      o_over_temp_flag           <= ot_nxt;
      o_thermal_warning_flag     <= otw_nxt;
      o_thermal_shutdown_flag    <= tsd_nxt;
      o_motor_stall_event        <= st_rep;
      o_stall_cond_flag          <= stc_nxt;
    end
  end

endmodule // frp_top

//--- test/frp_host_model.sv
// Host-side model that issues one-cycle clear-fault pulses
`timescale 1ns/100ps
module frp_host_model (
  input  wire logic i_mclk,   // Clock
  input  wire logic i_rst_n,  // Reset, active low
  input  wire logic i_req,    // Bench asks for a clear
  output logic      o_clear   // Clear-fault pulse
);
  logic pend_r;
  // Sampled on rise, driven on fall: the pulse always spans one whole edge
  always @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n) pend_r <= 1'b0; else pend_r <= i_req;
  always @(negedge i_mclk or negedge i_rst_n)
    if (!i_rst_n) o_clear <= 1'b0; else o_clear <= pend_r && !o_clear;
endmodule // frp_host_model

//--- test/frp_monitor.sv
// Concurrent checks on the fault-response block ports
`timescale 1ns/100ps
module frp_monitor
  import frp_pkg::*;
(
  input wire logic       i_mclk,                      // Clock
  input wire logic       i_rst_n,                     // Reset
  input wire logic       i_motor_supply_ov,           // Supply trip
  input wire logic       i_thermal_shutdown,          // Shutdown flag
  input wire logic       i_overvoltage_enable,        // Supply protection on
  input wire logic [1:0] i_overcurrent_response_mode, // Overcurrent mode
  input wire logic [3:0] i_hw_current_limit_mode,     // Limit mode
  input wire logic       i_clear_fault_cmd,           // Clear pulse
  input wire logic       o_fault_out_n,               // Fault pin
  input wire frp_bridge_t o_bridge_state,             // Bridge state
  input wire logic       o_charge_pump_en,            // Pump enable
  input wire logic       o_driver_fault,              // Summary
  input wire logic       o_controller_fault,          // Summary
  input wire logic       o_overvoltage_flag,          // Sticky
  input wire logic       o_overcurrent_flag,          // Sticky
  input wire logic [5:0] o_fet_oc_flag,               // Per FET
  input wire logic       o_hw_current_limit_flag,     // Limit
  input wire logic       o_over_temp_flag,            // Sticky
  input wire logic       o_thermal_warning_flag,      // Sticky
  input wire logic       o_thermal_shutdown_flag      // Sticky
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic any_flag;
  assign any_flag = o_driver_fault || o_controller_fault || o_thermal_warning_flag;
  sequence s_ov_held; (i_motor_supply_ov && i_overvoltage_enable) [*5]; endsequence
  sequence s_tsd_held; i_thermal_shutdown [*5]; endsequence
  property p_ov_action; s_ov_held |-> !o_fault_out_n && o_bridge_state == FRP_BR_OFF && o_driver_fault; endproperty
  a_ov_action: assert property (p_ov_action) else $error("Supply trip left bridge on");
  property p_ov_cause; $rose(o_overvoltage_flag) |-> $past(i_motor_supply_ov, 3); endproperty
  a_ov_cause: assert property (p_ov_cause) else $error("Supply flag set without trip");
  property p_ov_sticky; o_overvoltage_flag && !i_clear_fault_cmd |=> o_overvoltage_flag; endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("Supply flag lost");
  property p_clear_cause; $fell(o_overvoltage_flag) |-> $past(i_clear_fault_cmd); endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("Supply flag cleared unasked");
  property p_tsd_action;
    s_tsd_held |-> !o_charge_pump_en && !o_fault_out_n && o_thermal_shutdown_flag && o_over_temp_flag;
  endproperty
  a_tsd_action: assert property (p_tsd_action) else $error("Shutdown not applied");
  property p_tsd_sticky; o_thermal_shutdown_flag && !i_clear_fault_cmd |=> o_thermal_shutdown_flag; endproperty
  a_tsd_sticky: assert property (p_tsd_sticky) else $error("Shutdown flag lost");
  property p_oc_ignore; (i_overcurrent_response_mode == 2'h3) [*8] |-> !o_overcurrent_flag && o_fet_oc_flag == 6'h00; endproperty
  a_oc_ignore: assert property (p_oc_ignore) else $error("Ignored overcurrent reported");
  property p_lim_ignore; (i_hw_current_limit_mode[3] && i_hw_current_limit_mode[0]) [*8] |-> !o_hw_current_limit_flag; endproperty
  a_lim_ignore: assert property (p_lim_ignore) else $error("Ignored limit reported");
  property p_pin_cause; !o_fault_out_n |-> any_flag || $past(any_flag); endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("Pin low with no fault");
endmodule // frp_monitor

bind frp_top frp_monitor mon_u (.*);

//--- test/motor_driver_fault_protection_tb_top.sv
// Self-checking bench for the fault-response block
`timescale 1ns/100ps
module motor_driver_fault_protection_tb_top;
  import frp_pkg::*;
  localparam int OCA = 60, OCB = 90, STA = 120, STB = 150;
  logic        i_mclk, i_rst_n, i_motor_supply_ov, i_buck_oc, i_current_sense_amp_over, i_thermal_warning;
  logic        i_thermal_shutdown, i_overvoltage_enable, i_overvoltage_level_select, i_overcurrent_retry_time;
  logic        i_alarm_pin_disable, i_stall_retry_time, i_thermal_warning_report, i_clear_fault_cmd, host_req;
  logic [5:0]  i_fet_oc, o_fet_oc_flag;
  logic [2:0]  i_stall_cond, i_stall_enable, o_stall_cond_flag;
  logic [1:0]  i_overcurrent_response_mode, i_overcurrent_level, i_overcurrent_deglitch;
  logic [1:0]  i_hw_current_limit_deglitch, o_overcurrent_level;
  logic [3:0]  i_hw_current_limit, i_hw_current_limit_mode, i_motor_stall_mode, o_hw_current_limit;
  logic        o_fault_out_n, o_charge_pump_en, o_device_reset, o_overvoltage_level_select, o_driver_fault;
  logic        o_controller_fault, o_overvoltage_flag, o_overcurrent_flag, o_hw_current_limit_flag;
  logic        o_over_temp_flag, o_thermal_warning_flag, o_thermal_shutdown_flag, o_motor_stall_event;
  frp_bridge_t o_bridge_state;
  int          mismatches, num_checks, seed;
  int          ocd[4] = '{25, 50, 100, 200};
  int          ild[4] = '{100, 200, 500, 1000};

  frp_top #(.OC_RETRY_A_CYC(OCA), .OC_RETRY_B_CYC(OCB), .STALL_RETRY_A_CYC(STA), .STALL_RETRY_B_CYC(STB)) dut_u (.*);
  frp_host_model host_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(host_req), .o_clear(i_clear_fault_cmd));

  always #5 i_mclk = ~i_mclk;

  // --------
  // Helpers
  // --------
  task tick(input int n); repeat (n) @(negedge i_mclk); endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_br(input frp_bridge_t got, input frp_bridge_t exp); chk({5'h00, got}, {5'h00, exp}); endtask
  task host_clear; host_req = 1'b1; tick(1); host_req = 1'b0; tick(4); endtask
  task close_out;
    $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic frp_class_t cls_of(input int k, input logic [3:0] m);
    if (k == 0) return frp_class_t'(m[1:0]);
    if (!m[3]) return frp_class_t'({1'b0, m[2]});
    return m[0] ? FRP_CL_IGNORE : FRP_CL_REPORT;
  endfunction
  function automatic frp_bridge_t br_of(input int k, input logic [3:0] m);
    return (k == 0) ? FRP_BR_OFF : frp_bridge_t'({1'b0, m[1:0]} + 3'h1);
  endfunction
  function automatic logic flag_of(input int k);
    return (k == 0) ? o_overcurrent_flag : (k == 1) ? o_hw_current_limit_flag : o_motor_stall_event;
  endfunction

  // --------
  // One overcurrent, limit or stall event under mode m
  // --------
  task automatic lock_case(input int k, input logic [3:0] m);
    frp_class_t c;
    logic [5:0] b, eb;
    logic       act, rep, apd, stay;
    int         l, r;
    c = cls_of(k, m);
    act = (c == FRP_CL_LATCH) || (c == FRP_CL_RETRY);
    rep = (c != FRP_CL_IGNORE);
    stay = (c == FRP_CL_LATCH) || (c == FRP_CL_REPORT) || (c == FRP_CL_RETRY && k == 0);
    b = 6'h01 << ($unsigned($random(seed)) % 6);
    eb = (k == 0) ? b : (k == 2) ? {3'h0, b[5:3] | b[2:0]} : 6'h00;
    {i_alarm_pin_disable, i_overcurrent_deglitch, i_hw_current_limit_deglitch, i_overcurrent_retry_time,
     i_stall_retry_time, i_overcurrent_level, i_hw_current_limit} = 13'($random(seed));
    apd = i_alarm_pin_disable;
    i_overcurrent_response_mode = (k == 0) ? m[1:0] : 2'h3;
    i_hw_current_limit_mode = (k == 1) ? m : 4'h9;
    i_motor_stall_mode = (k == 2) ? m : 4'h9;
    l = (k == 0) ? ocd[i_overcurrent_deglitch] : (k == 1) ? ild[i_hw_current_limit_deglitch] : 0;
    r = (k == 0) ? (i_overcurrent_retry_time ? OCB : OCA) : (i_stall_retry_time ? STB : STA);
    tick(10);
    chk(o_overcurrent_level, i_overcurrent_level);
    chk(o_hw_current_limit, i_hw_current_limit);
    i_fet_oc = (k == 0) ? b : 6'h00;
    i_current_sense_amp_over = (k == 1);
    i_stall_cond = (k == 2) ? eb[2:0] : 3'h0;
    tick(l + 12);
    chk_br(o_bridge_state, act ? br_of(k, m) : FRP_BR_DRIVE);
    chk(o_fault_out_n, !(act || (rep && !apd)));
    chk(flag_of(k), rep);
    chk((k == 0) ? o_driver_fault : o_controller_fault, rep);
    chk((k == 0) ? o_fet_oc_flag : {3'h0, o_stall_cond_flag}, rep ? eb : 6'h00);
    i_fet_oc = 6'h00;
    i_current_sense_amp_over = 1'b0;
    i_stall_cond = 3'h0;
    tick((c == FRP_CL_RETRY) ? r + 12 : 10);
    chk_br(o_bridge_state, (c == FRP_CL_LATCH) ? br_of(k, m) : FRP_BR_DRIVE);
    chk(flag_of(k), stay);
    chk((k == 0) ? o_driver_fault : o_controller_fault, stay && c != FRP_CL_RETRY);
    chk(o_fault_out_n, !(c == FRP_CL_LATCH || (c == FRP_CL_REPORT && !apd)));
    host_clear;
    chk(flag_of(k), 1'b0);
    chk(o_fault_out_n, 1'b1);
  endtask

  initial
  begin
    repeat (100000) @(posedge i_mclk);
    mismatches++;
    close_out;
  end

  // --------
  // Main sequence
  // --------
  initial
  begin
    seed = 32'h2593;
    {i_mclk, i_rst_n, i_motor_supply_ov, i_buck_oc, i_current_sense_amp_over, i_thermal_warning} = 6'h00;
    {i_thermal_shutdown, i_overvoltage_enable, i_overvoltage_level_select, i_overcurrent_retry_time} = 4'h0;
    {i_alarm_pin_disable, i_stall_retry_time, i_thermal_warning_report, host_req} = 4'h0;
    {i_fet_oc, i_stall_cond, i_overcurrent_level, i_overcurrent_deglitch, i_hw_current_limit_deglitch} = 17'h00000;
    i_stall_enable = 3'h7;
    i_overcurrent_response_mode = 2'h3;
    i_hw_current_limit = 4'h0;
    i_hw_current_limit_mode = 4'h9;
    i_motor_stall_mode = 4'h9;
    tick(10);
    i_rst_n = 1'b1;
    tick(2);
    chk(o_fault_out_n, 1'b1);
    chk_br(o_bridge_state, FRP_BR_DRIVE);
    chk(o_charge_pump_en, 1'b1);
    i_overvoltage_enable = 1'b1;
    i_overvoltage_level_select = $random(seed);
    i_motor_supply_ov = 1'b1;
    tick(6);
    chk(o_overvoltage_level_select, i_overvoltage_level_select);
    chk_br(o_bridge_state, FRP_BR_OFF);
    chk({o_fault_out_n, o_driver_fault, o_overvoltage_flag}, 3'h3);
    host_clear;
    chk(o_overvoltage_flag, 1'b1);
    i_motor_supply_ov = 1'b0;
    tick(6);
    chk({o_fault_out_n, o_driver_fault, o_overvoltage_flag}, 3'h5);
    host_clear;
    chk(o_overvoltage_flag, 1'b0);
    i_overvoltage_enable = 1'b0;
    i_motor_supply_ov = 1'b1;
    tick(6);
    chk({o_fault_out_n, o_overvoltage_flag}, 2'h2);
    i_motor_supply_ov = 1'b0;
    i_thermal_shutdown = 1'b1;
    tick(6);
    chk({o_charge_pump_en, o_fault_out_n, o_thermal_shutdown_flag, o_over_temp_flag}, 4'h3);
    i_thermal_shutdown = 1'b0;
    tick(6);
    chk({o_charge_pump_en, o_fault_out_n, o_thermal_shutdown_flag}, 3'h7);
    host_clear;
    chk({o_thermal_shutdown_flag, o_over_temp_flag}, 2'h0);
    i_thermal_warning_report = $random(seed);
    i_thermal_warning = 1'b1;
    tick(6);
    chk({o_fault_out_n, o_thermal_warning_flag, o_over_temp_flag}, {!i_thermal_warning_report, 2'h3});
    chk_br(o_bridge_state, FRP_BR_DRIVE);
    host_clear;
    chk(o_thermal_warning_flag, 1'b1);
    i_thermal_warning = 1'b0;
    tick(6);
    chk({o_fault_out_n, o_thermal_warning_flag}, 2'h3);
    host_clear;
    chk(o_thermal_warning_flag, 1'b0);
    i_overcurrent_deglitch = $random(seed);
    i_buck_oc = 1'b1;
    tick(ocd[i_overcurrent_deglitch] + 12);
    chk(o_device_reset, 1'b1);
    i_buck_oc = 1'b0;
    tick(6);
    chk(o_device_reset, 1'b0);
    for (int i = 0; i < 4; i++) lock_case(0, i[3:0]);
    for (int i = 0; i < 16; i++) lock_case(1, i[3:0]);
    for (int i = 0; i < 16; i++) lock_case(2, i[3:0]);
    close_out;
  end
endmodule // motor_driver_fault_protection_tb_top
